// ===== src/dma_consts.svh
`ifndef DMA_CONSTS_SVH
`define DMA_CONSTS_SVH

// register byte addresses
`define DMA_OFS_OPER      32'hFFFF86B0
`define DMA_OFS_CH0_SRC   32'hFFFF86C0
`define DMA_OFS_CH0_DST   32'hFFFF86C4
`define DMA_OFS_CH0_CNT   32'hFFFF86C8
`define DMA_OFS_CH0_CTRL  32'hFFFF86CC
`define DMA_OFS_CH1_SRC   32'hFFFF86D0
`define DMA_OFS_CH1_DST   32'hFFFF86D4
`define DMA_OFS_CH1_CNT   32'hFFFF86D8
`define DMA_OFS_CH1_CTRL  32'hFFFF86DC
`define DMA_CH_DECODE_MASK 32'hFFFFFFE3

// channel control fields
`define CTRL_EN         0
`define CTRL_END        1
`define CTRL_SIZE_LO    3
`define CTRL_EDGE       6
`define CTRL_SEL_LO     8
`define CTRL_SRCMODE_LO 12
`define CTRL_DSTMODE_LO 14
`define CTRL_STB_POL    16
`define CTRL_TAKEN_POL  18
`define CTRL_RW_MASK    32'h0007FF7D
`define CTRL_RESET      32'h00000000

// resource select codes for external requests
`define RS_EXT_DUAL    4'h0
`define RS_EXT_DEV_SRC 4'h2
`define RS_EXT_DEV_DST 4'h3

// address mode codes
`define AM_INC 2'h1
`define AM_DEC 2'h2

// shared operation fields
`define OPER_DME   0
`define OPER_NMIF  1
`define OPER_AE    2
`define OPER_RESET 16'h0000

`endif

// ===== src/dma_pkg.sv
package dma_pkg;

  // engine states
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } state_t;

  // register selected by the bus address
  typedef enum logic [5:0]
  {
    SEL_NONE = 6'b000001,
    SEL_OPER = 6'b000010,
    SEL_SRC  = 6'b000100,
    SEL_DST  = 6'b001000,
    SEL_CNT  = 6'b010000,
    SEL_CTRL = 6'b100000
  } regsel_t;

endpackage

// ===== src/dma_channel_regs.sv
`timescale 1ns/1ns
`include "dma_consts.svh"

module dma_channel_regs
  import dma_pkg::*;
(
  input  wire logic        clk,                   // system clock
  input  wire logic        reset_n,               // async reset
  input  wire logic [31:0] regAddr,               // register byte address
  input  wire logic [31:0] regWrData,             // write data
  input  wire logic [1:0]  regWrHalf,             // half enables, 1=upper
  input  wire logic        regWr,                 // write strobe
  input  wire logic        regRd,                 // read strobe
  output logic      [31:0] regRdData,             // read data, next cycle
  input  wire logic        ch0_xfer_request_in,   // channel 0 request pin
  input  wire logic        ch1_xfer_request_in,   // channel 1 request pin
  input  wire logic        addrErrIn,             // address error event
  input  wire logic        nmiIn,                 // nmi event
  output logic             ch0_xfer_strobe_out,   // channel 0 strobe
  output logic             ch1_xfer_strobe_out,   // channel 1 strobe
  output logic             ch0_request_taken_out, // channel 0 sampled
  output logic             ch1_request_taken_out  // channel 1 sampled
);

  // ==========================================================
  // storage
  logic [31:0] srcAddr_r [2];
  logic [31:0] dstAddr_r [2];
  logic [15:0] count_r   [2];
  logic [31:0] ctrl_r    [2];
  logic [1:0]  te_r;
  logic [1:0]  teSeen_r;
  logic        dme_r;
  logic        nmif_r;
  logic        ae_r;
  logic        nmifSeen_r;
  logic        aeSeen_r;
  state_t      state_r;
  logic        curCh_r;
  logic [1:0]  reqS1_r;
  logic [1:0]  reqS2_r;
  logic [1:0]  reqPrev_r;
  logic [1:0]  edgeHit_r;
  logic [1:0]  evS1_r;
  logic [1:0]  evS2_r;
  logic [1:0]  strobe_r;
  logic [1:0]  taken_r;
  logic [31:0] rdData_r;

  // ==========================================================
  // address decode
  regsel_t     sel;
  logic        selCh;

  // unaligned or unlisted addresses select nothing
  always_comb
  begin
    selCh = regAddr[4];
    if (regAddr == `DMA_OFS_OPER)
      sel = SEL_OPER;
    else if ((regAddr & `DMA_CH_DECODE_MASK) == `DMA_OFS_CH0_SRC)
    begin
      if (regAddr[3:2] == 2'h0)
        sel = SEL_SRC;
      else if (regAddr[3:2] == 2'h1)
        sel = SEL_DST;
      else if (regAddr[3:2] == 2'h2)
        sel = SEL_CNT;
      else
        sel = SEL_CTRL;
    end
    else
      sel = SEL_NONE;
  end

  // keep the half not written
  function automatic logic [31:0] mergeHalf(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [1:0]  en);
    mergeHalf = {en[1] ? wd[31:16] : old[31:16],
                 en[0] ? wd[15:0]  : old[15:0]};
  endfunction

  // ==========================================================
  // request pins and flag events, two flops each
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reqS1_r   <= 2'h3;
      reqS2_r   <= 2'h3;
      reqPrev_r <= 2'h3;
      evS1_r    <= 2'h0;
      evS2_r    <= 2'h0;
    end
    else
    begin
      reqS1_r   <= {ch1_xfer_request_in, ch0_xfer_request_in};
      reqS2_r   <= reqS1_r;
      reqPrev_r <= reqS2_r;
      evS1_r    <= {addrErrIn, nmiIn};
      evS2_r    <= evS1_r;
    end
  end

  // ==========================================================
  // request detection and arbitration
  logic [1:0]  pending;
  logic [1:0]  eligible;
  logic        grantAny;
  logic        grantCh;
  logic [1:0]  fall;

  always_comb
  begin
    fall = reqPrev_r & ~reqS2_r;
    for (int c = 0; c < 2; c++)
    begin
      // edge mode latches the fall, level mode looks at the pin
      pending[c] = ctrl_r[c][`CTRL_EDGE] ? edgeHit_r[c] : ~reqS2_r[c];
      eligible[c] = pending[c] & ctrl_r[c][`CTRL_EN] & dme_r & ~te_r[c]
                    & ~nmif_r & ~ae_r
                    & (ctrl_r[c][`CTRL_SEL_LO+:4] == `RS_EXT_DUAL
                    |  ctrl_r[c][`CTRL_SEL_LO+:4] == `RS_EXT_DEV_SRC
                    |  ctrl_r[c][`CTRL_SEL_LO+:4] == `RS_EXT_DEV_DST);
    end
    grantAny = (state_r == ST_IDLE) && (eligible != 2'h0);
    grantCh  = !eligible[0];
  end

  // falling-edge latch; a new edge wins over the grant clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      edgeHit_r <= 2'h0;
    else
      for (int c = 0; c < 2; c++)
        if (fall[c])
          edgeHit_r[c] <= 1'b1;
        else if (grantAny && grantCh == c[0])
          edgeHit_r[c] <= 1'b0;
  end

  // ==========================================================
  // engine: one grant cycle, one strobe cycle per unit
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= ST_IDLE;
      curCh_r <= 1'b0;
    end
    else
      case (state_r)
        ST_IDLE:
          if (grantAny)
          begin
            state_r <= ST_RUN;
            curCh_r <= grantCh;
          end
        ST_RUN:
          state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
  end

  // pins are registered with their polarity applied
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strobe_r <= 2'h0;
      taken_r  <= 2'h0;
    end
    else
      for (int c = 0; c < 2; c++)
      begin
        strobe_r[c] <= (grantAny && grantCh == c[0])
                       ^ ctrl_r[c][`CTRL_STB_POL];
        taken_r[c]  <= (grantAny && grantCh == c[0])
                       ^ ctrl_r[c][`CTRL_TAKEN_POL];
      end
  end

  assign ch0_xfer_strobe_out   = strobe_r[0];
  assign ch1_xfer_strobe_out   = strobe_r[1];
  assign ch0_request_taken_out = taken_r[0];
  assign ch1_request_taken_out = taken_r[1];

  // ==========================================================
  // per-channel registers; hardware update wins in its cycle
  logic [31:0] step [2];
  logic [1:0]  runCh;
  logic [1:0]  ignSrc;
  logic [1:0]  ignDst;
  logic [1:0]  teClr;

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      step[c] = (ctrl_r[c][`CTRL_SIZE_LO+:2] == 2'h0) ? 32'h00000001 :
                (ctrl_r[c][`CTRL_SIZE_LO+:2] == 2'h1) ? 32'h00000002 :
                                                      32'h00000004;
      runCh[c]  = (state_r == ST_RUN) && (curCh_r == c[0]);
      ignSrc[c] = ctrl_r[c][`CTRL_SEL_LO+:4] == `RS_EXT_DEV_SRC;
      ignDst[c] = ctrl_r[c][`CTRL_SEL_LO+:4] == `RS_EXT_DEV_DST;
      teClr[c]  = regWr && sel == SEL_CTRL && selCh == c[0]
                  && regWrHalf[0] && !regWrData[`CTRL_END] && teSeen_r[c];
    end
  end

  // address counters; reset value is a don't-care for software
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      for (int c = 0; c < 2; c++)
      begin
        srcAddr_r[c] <= 32'h00000000;
        dstAddr_r[c] <= 32'h00000000;
      end
    else
      for (int c = 0; c < 2; c++)
      begin
        if (runCh[c] && !ignSrc[c]
            && ctrl_r[c][`CTRL_SRCMODE_LO+:2] == `AM_INC)
          srcAddr_r[c] <= srcAddr_r[c] + step[c];
        else if (runCh[c] && !ignSrc[c]
                 && ctrl_r[c][`CTRL_SRCMODE_LO+:2] == `AM_DEC)
          srcAddr_r[c] <= srcAddr_r[c] - step[c];
        else if (!runCh[c] && regWr && sel == SEL_SRC && selCh == c[0])
          srcAddr_r[c] <= mergeHalf(srcAddr_r[c], regWrData,
                                    regWrHalf);
        if (runCh[c] && !ignDst[c]
            && ctrl_r[c][`CTRL_DSTMODE_LO+:2] == `AM_INC)
          dstAddr_r[c] <= dstAddr_r[c] + step[c];
        else if (runCh[c] && !ignDst[c]
                 && ctrl_r[c][`CTRL_DSTMODE_LO+:2] == `AM_DEC)
          dstAddr_r[c] <= dstAddr_r[c] - step[c];
        else if (!runCh[c] && regWr && sel == SEL_DST && selCh == c[0])
          dstAddr_r[c] <= mergeHalf(dstAddr_r[c], regWrData,
                                    regWrHalf);
      end
  end

  // count: zero wraps to 16'hFFFF so it gives 65,536 units
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      for (int c = 0; c < 2; c++)
        count_r[c] <= 16'h0000;
    else
      for (int c = 0; c < 2; c++)
        if (runCh[c])
          count_r[c] <= count_r[c] - 16'h0001;
        else if (regWr && sel == SEL_CNT && selCh == c[0]
                 && regWrHalf[0])
          count_r[c] <= regWrData[15:0];
  end

  // channel control; end flag kept apart so only the last unit and a clear touch it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int c = 0; c < 2; c++)
        ctrl_r[c] <= `CTRL_RESET;
      te_r     <= 2'h0;
      teSeen_r <= 2'h0;
    end
    else
      for (int c = 0; c < 2; c++)
      begin
        if (regWr && sel == SEL_CTRL && selCh == c[0])
          ctrl_r[c] <= mergeHalf(ctrl_r[c], regWrData, regWrHalf)
                       & `CTRL_RW_MASK;
        if (runCh[c] && count_r[c] == 16'h0001)
          te_r[c] <= 1'b1;
        else if (teClr[c])
          te_r[c] <= 1'b0;
        if (regRd && sel == SEL_CTRL && selCh == c[0] && te_r[c])
          teSeen_r[c] <= 1'b1;
        else if (regWr && sel == SEL_CTRL && selCh == c[0])
          teSeen_r[c] <= 1'b0;
      end
  end

  // ==========================================================
  // shared operation register, low half only
  logic        operWr;

  assign operWr = regWr && sel == SEL_OPER && regWrHalf[0];

  // an event in the clearing cycle keeps its flag
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dme_r      <= 1'b0;
      nmif_r     <= 1'b0;
      ae_r       <= 1'b0;
      nmifSeen_r <= 1'b0;
      aeSeen_r   <= 1'b0;
    end
    else
    begin
      if (operWr)
        dme_r <= regWrData[`OPER_DME];
      if (evS2_r[0])
        nmif_r <= 1'b1;
      else if (operWr && !regWrData[`OPER_NMIF] && nmifSeen_r)
        nmif_r <= 1'b0;
      if (evS2_r[1])
        ae_r <= 1'b1;
      else if (operWr && !regWrData[`OPER_AE] && aeSeen_r)
        ae_r <= 1'b0;
      if (regRd && sel == SEL_OPER)
      begin
        nmifSeen_r <= nmif_r;
        aeSeen_r   <= ae_r;
      end
      else if (operWr)
      begin
        nmifSeen_r <= 1'b0;
        aeSeen_r   <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read path: nine registers, unmapped reads zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdData_r <= 32'h00000000;
    else if (regRd)
    begin
      if (sel == SEL_OPER)
        rdData_r <= {29'h00000000, ae_r, nmif_r, dme_r};
      else if (sel == SEL_SRC)
        rdData_r <= srcAddr_r[selCh];
      else if (sel == SEL_DST)
        rdData_r <= dstAddr_r[selCh];
      else if (sel == SEL_CNT)
        rdData_r <= {16'h0000, count_r[selCh]};
      else if (sel == SEL_CTRL)
        rdData_r <= ctrl_r[selCh] | {30'h00000000, te_r[selCh], 1'b0};
      else
        rdData_r <= 32'h00000000;
    end
    else
      rdData_r <= 32'h00000000;
  end

  assign regRdData = rdData_r;

  // ==========================================================
  // checks
  a_strobe_ch0_grant:
    assert property (@(posedge clk) disable iff (!reset_n)
      (grantAny && !grantCh) |=>
        (ch0_xfer_strobe_out == !$past(ctrl_r[0][`CTRL_STB_POL])))
    else $error("ch0 strobe not active after grant");

  a_taken_with_strobe:
    assert property (@(posedge clk) disable iff (!reset_n)
      (grantAny && grantCh) |=>
        (ch1_request_taken_out != $past(ctrl_r[1][`CTRL_TAKEN_POL]))
        && (state_r == ST_RUN) ##1 (state_r == ST_IDLE))
    else $error("ch1 sampled output missing in strobe cycle");

  a_te_hold_flag:
    assert property (@(posedge clk) disable iff (!reset_n)
      (te_r[0] && !teClr[0]) |=> te_r[0])
    else $error("end flag cleared without read-then-zero");

  a_half_write_keeps:
    assert property (@(posedge clk) disable iff (!reset_n)
      (regWr && sel == SEL_SRC && !selCh && regWrHalf == 2'b01
       && !runCh[0]) |=> ($stable(srcAddr_r[0][31:16])))
    else $error("upper half changed on lower half write");

  a_count_upper_zero:
    assert property (@(posedge clk) disable iff (!reset_n)
      (regRd && sel == SEL_CNT) |=> (regRdData[31:16] == 16'h0000))
    else $error("count upper bits not zero");

  a_src_counts_up:
    assert property (@(posedge clk) disable iff (!reset_n)
      (runCh[0] && !ignSrc[0] && ctrl_r[0][`CTRL_SRCMODE_LO+:2] == `AM_INC)
        |=> (srcAddr_r[0] == $past(srcAddr_r[0]) + $past(step[0])))
    else $error("source address did not step");

  a_dst_ignored:
    assert property (@(posedge clk) disable iff (!reset_n)
      (runCh[0] && ignDst[0]) |=> $stable(dstAddr_r[0]))
    else $error("destination moved while ignored");

  a_fixed_priority:
    assert property (@(posedge clk) disable iff (!reset_n)
      (state_r == ST_IDLE && eligible == 2'b11)
        |=> (state_r == ST_RUN && !curCh_r))
    else $error("channel 1 won over channel 0");

  a_count_end_flag:
    assert property (@(posedge clk) disable iff (!reset_n)
      (runCh[1] && count_r[1] == 16'h0001)
        |=> (te_r[1] && count_r[1] == 16'h0000) ##1 !runCh[1])
    else $error("last unit did not end channel");

endmodule

// ===== dv/periph_model.sv
`timescale 1ns/1ns

// ==============================================================
// external requester standing on one channel's request pin
module periph_model
(
  input  wire logic       clk,     // system clock
  input  wire logic       reset_n, // async reset
  input  wire logic       fire,    // ask for one unit
  input  wire logic [3:0] lag,     // cycles before pin falls
  input  wire logic       strobe,  // strobe from channel
  input  wire logic       actLow,  // strobe polarity in use
  output logic            reqN     // request pin, active low
);
  logic [3:0] waitCnt_r;
  logic       armed_r;

  // pin idles high on its pull-up; a slow device waits lag cycles
  // release only on the strobe, so one fall asks for one unit
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reqN      <= 1'b1;
      armed_r   <= 1'b0;
      waitCnt_r <= 4'h0;
    end
    else if (fire)
    begin
      armed_r   <= 1'b1;
      waitCnt_r <= lag;
    end
    else if (armed_r && waitCnt_r != 4'h0)
      waitCnt_r <= waitCnt_r - 4'h1;
    else if (armed_r)
    begin
      reqN    <= 1'b0;
      armed_r <= 1'b0;
    end
    else if (strobe ^ actLow)
      reqN <= 1'b1;
  end
endmodule

// ===== dv/tb_dma_channel_regs.sv
`timescale 1ns/1ns
`include "dma_consts.svh"

`define CHK(nm, ex, gt) \
  begin \
    totalChecks++; \
    if ((gt) !== (ex)) \
    begin \
      errCount++; \
      $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); \
    end \
  end

module tb_dma_channel_regs
  import dma_pkg::*;
;
  logic        clk, reset_n, regWr, regRd, nmiIn, addrErrIn;
  logic [31:0] regAddr, regWrData, regRdData;
  logic [1:0]  regWrHalf;
  logic        req0N, req1N, stb0, stb1, tak0, tak1;
  logic        fire0, fire1, al0, al1;
  logic [3:0]  lag;
  int          errCount, totalChecks, cycles;

  // ============================================================
  // design and the two requesters
  dma_channel_regs u_dma_channel_regs (.clk(clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrHalf(regWrHalf),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .ch0_xfer_request_in(req0N), .ch1_xfer_request_in(req1N),
    .addrErrIn(addrErrIn), .nmiIn(nmiIn),
    .ch0_xfer_strobe_out(stb0), .ch1_xfer_strobe_out(stb1),
    .ch0_request_taken_out(tak0), .ch1_request_taken_out(tak1));
  periph_model u_periph_model0 (.clk(clk), .reset_n(reset_n),
    .fire(fire0), .lag(lag), .strobe(stb0), .actLow(al0), .reqN(req0N));
  periph_model u_periph_model1 (.clk(clk), .reset_n(reset_n),
    .fire(fire1), .lag(lag), .strobe(stb1), .actLow(al1), .reqN(req1N));

  always #5 clk = ~clk;

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errCount++;
      conclude();
    end
  end

  // ============================================================
  // bus and pin helpers
  task automatic conclude;
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, d, input logic [1:0] h);
    @(posedge clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    regWrHalf <= h;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic chkRd(input string nm, input logic [31:0] a, ex);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 `CHK(nm, ex, regRdData)
  endtask

  task automatic kick(input logic [1:0] which);
    @(posedge clk);
    fire0 <= which[0];
    fire1 <= which[1];
    @(posedge clk);
    fire0 <= 1'b0;
    fire1 <= 1'b0;
  endtask

  // returns inside the strobe cycle so the taken pin can be judged
  task automatic waitStb(input logic [1:0] which, output logic [1:0] s);
    int n;
    s = 2'b00;
    n = 0;
    while (s == 2'b00 && n < 40)
    begin
      @(posedge clk);
      #1 s = {stb1 ^ al1, stb0 ^ al0} & which;
      n++;
    end
  endtask

  task automatic doReset;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
  endtask

  // ============================================================
  // scenarios
  task automatic testRegs;
    chkRd("ctrl0", `DMA_OFS_CH0_CTRL, `CTRL_RESET);
    chkRd("ctrl1", `DMA_OFS_CH1_CTRL, `CTRL_RESET);
    chkRd("oper", `DMA_OFS_OPER, 32'h00000000);
    chkRd("unmapped", 32'h00000100, 32'h00000000);
    @(posedge clk);
    #1 `CHK("rdGone", 32'h00000000, regRdData)
    wr(`DMA_OFS_CH0_SRC, 32'h11223344, 2'b11);
    wr(`DMA_OFS_CH0_SRC, 32'hAABB0000, 2'b10);
    chkRd("srcHi", `DMA_OFS_CH0_SRC, 32'hAABB3344);
    wr(`DMA_OFS_CH0_DST, 32'h0000CCDD, 2'b01);
    chkRd("dstLo", `DMA_OFS_CH0_DST, 32'h0000CCDD);
    wr(`DMA_OFS_CH0_CTRL, 32'hFFFF0000, 2'b10);
    chkRd("ctrlHi", `DMA_OFS_CH0_CTRL, 32'h00070000);
    wr(`DMA_OFS_CH0_CTRL, 32'h00000000, 2'b11);
    wr(`DMA_OFS_CH0_CNT, 32'hFFFF1234, 2'b11);
    chkRd("cntHi", `DMA_OFS_CH0_CNT, 32'h00001234);
    $display("test registers done");
  endtask

  // edge request, low-going strobe and taken, two 2-byte units
  task automatic testXfer;
    logic [1:0] s;
    al0 = 1'b1;
    wr(`DMA_OFS_OPER, 32'h00000001, 2'b01);
    wr(`DMA_OFS_CH0_SRC, 32'h00001000, 2'b11);
    wr(`DMA_OFS_CH0_DST, 32'h00002000, 2'b11);
    wr(`DMA_OFS_CH0_CNT, 32'h00000002, 2'b11);
    wr(`DMA_OFS_CH0_CTRL, 32'h00055049, 2'b11);
    repeat (2) @(posedge clk);
    #1 `CHK("idle0", 1'b1, stb0)
    kick(2'b01);
    waitStb(2'b01, s);
    `CHK("unit1", 2'b01, s)
    `CHK("taken0", 1'b0, tak0)
    chkRd("src1", `DMA_OFS_CH0_SRC, 32'h00001002);
    chkRd("dst1", `DMA_OFS_CH0_DST, 32'h00002002);
    chkRd("cnt1", `DMA_OFS_CH0_CNT, 32'h00000001);
    lag = 4'h6;
    kick(2'b01);
    waitStb(2'b01, s);
    `CHK("unit2", 2'b01, s)
    chkRd("src2", `DMA_OFS_CH0_SRC, 32'h00001004);
    chkRd("ctrlEnd", `DMA_OFS_CH0_CTRL, 32'h0005504B);
    wr(`DMA_OFS_CH0_CTRL, 32'h00055048, 2'b11);
    chkRd("teClr", `DMA_OFS_CH0_CTRL, 32'h00055048);
    lag = 4'h0;
    $display("test transfer done");
  endtask

  // single address: device as source, then as destination
  task automatic testSingle;
    logic [1:0] s;
    wr(`DMA_OFS_OPER, 32'h00000001, 2'b01);
    wr(`DMA_OFS_CH1_SRC, 32'h00003000, 2'b11);
    wr(`DMA_OFS_CH1_DST, 32'h00004000, 2'b11);
    wr(`DMA_OFS_CH1_CNT, 32'h00000000, 2'b11);
    wr(`DMA_OFS_CH1_CTRL, 32'h00005251, 2'b11);
    kick(2'b10);
    waitStb(2'b10, s);
    `CHK("unitS", 2'b10, s)
    `CHK("taken1", 1'b1, tak1)
    chkRd("srcKeep", `DMA_OFS_CH1_SRC, 32'h00003000);
    chkRd("dstStep", `DMA_OFS_CH1_DST, 32'h00004004);
    chkRd("cntWrap", `DMA_OFS_CH1_CNT, 32'h0000FFFF);
    chkRd("noEnd", `DMA_OFS_CH1_CTRL, 32'h00005251);
    wr(`DMA_OFS_CH1_CTRL, 32'h00005351, 2'b11);
    kick(2'b10);
    waitStb(2'b10, s);
    chkRd("srcStep", `DMA_OFS_CH1_SRC, 32'h00003004);
    chkRd("dstKeep", `DMA_OFS_CH1_DST, 32'h00004004);
    chkRd("cntDec", `DMA_OFS_CH1_CNT, 32'h0000FFFE);
    $display("test single address done");
  endtask

  task automatic testPriority;
    logic [1:0] s;
    wr(`DMA_OFS_CH0_CNT, 32'h00000005, 2'b11);
    wr(`DMA_OFS_CH0_CTRL, 32'h00005049, 2'b11);
    kick(2'b11);
    waitStb(2'b11, s);
    `CHK("first", 2'b01, s)
    waitStb(2'b10, s);
    `CHK("second", 2'b10, s)
    // level mode: pin stays low through the sync delay, two units
    wr(`DMA_OFS_CH0_CTRL, 32'h00005009, 2'b11);
    kick(2'b01);
    repeat (20) @(posedge clk);
    chkRd("levelCnt", `DMA_OFS_CH0_CNT, 32'h00000002);
    $display("test priority done");
  endtask

  // each event flag survives a blind write, clears after a read
  task automatic testFlags;
    logic [31:0] f;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      nmiIn     <= (i == 0);
      addrErrIn <= (i == 1);
      repeat (3) @(posedge clk);
      nmiIn     <= 1'b0;
      addrErrIn <= 1'b0;
      repeat (4) @(posedge clk);
      f = 32'h00000002 << i;
      f[0] = 1'b1;
      wr(`DMA_OFS_OPER, 32'h00000001, 2'b01);
      chkRd("flagHeld", `DMA_OFS_OPER, f);
      wr(`DMA_OFS_OPER, 32'h00000001, 2'b01);
      chkRd("flagClr", `DMA_OFS_OPER, 32'h00000001);
    end
    $display("test flags done");
  endtask

  // ============================================================
  // main sequence
  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    {regWr, regRd, nmiIn, addrErrIn, fire0, fire1} = 6'h00;
    regAddr = 32'h00000000;
    regWrData = 32'h00000000;
    regWrHalf = 2'b00;
    {al0, al1} = 2'b00;
    lag = 4'h0;
    errCount = 0;
    totalChecks = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    testRegs();
    testXfer();
    al0 = 1'b0;
    doReset();
    testSingle();
    testPriority();
    testFlags();
    conclude();
  end
endmodule
